/* File: include/geht_consts.svh */
`ifndef GEHT_CONSTS_SVH
`define GEHT_CONSTS_SVH

// Power-up and device-clear defaults
`define GEHT_OPT_DEFAULT    2'h0
`define GEHT_TERM0_DEFAULT  8'h0D
`define GEHT_TERM1_DEFAULT  8'h0A
`define GEHT_TLEN_DEFAULT   2'h2

// Option field positions
`define GEHT_OPT_NO_EOI_BIT  0
`define GEHT_OPT_NO_HOLD_BIT 1

// Command letters
`define GEHT_CHR_OPT   8'h4B
`define GEHT_CHR_TERM  8'h59
`define GEHT_CHR_EXEC  8'h58
`define GEHT_CHR_FUNC  8'h46
`define GEHT_CHR_CAL   8'h43

// Character classes
`define GEHT_CHR_ZERO  8'h30
`define GEHT_CHR_THREE 8'h33
`define GEHT_CHR_NINE  8'h39
`define GEHT_CHR_UC_A  8'h41
`define GEHT_CHR_UC_Z  8'h5A
`define GEHT_CHR_BLANK 8'h20
`define GEHT_CHR_PLUS  8'h2B
`define GEHT_CHR_SLASH 8'h2F
`define GEHT_CHR_COMMA 8'h2C
`define GEHT_CHR_DOT   8'h2E
`define GEHT_CHR_LC_E  8'h65

// Hold-off times and clock rate
`define GEHT_CLK_KHZ     10000
`define GEHT_FUNC_MS     160
`define GEHT_AC_FUNC_MS  660
`define GEHT_OTHER_MS    200

`endif

/* File: include/geht_pkg.sv */
package geht_pkg;

   // Command parser states
   typedef enum logic [2:0] {
      GEHT_P_IDLE = 3'b000,
      GEHT_P_OPT  = 3'b001,
      GEHT_P_FUNC = 3'b010,
      GEHT_P_Y0   = 3'b011,
      GEHT_P_Y1   = 3'b100,
      GEHT_P_Y2   = 3'b101
   } geht_pst_e;

   // Output sequencer states
   typedef enum logic [1:0] {
      GEHT_O_DATA  = 2'b00,
      GEHT_O_TERM0 = 2'b01,
      GEHT_O_TERM1 = 2'b10
   } geht_ost_e;

endpackage

/* File: rtl/geht_top.sv */
// Function
// - Option 0 EOI+hold, 1 hold only, 2 EOI only, 3 neither.
// - Power-up or device clear restores the EOI/hold-off option default.
// - With EOI enabled, EOI accompanies the final byte of each output transfer.
// - With hold-off enabled, execute character holds NRFD until commands are processed.
// - Execute character handshake completes first; hold-off applies before next byte.
// - Held NRFD stalls the whole shared bus, not just this device.
// - Function select holds 160 ms, or 660 ms for AC functions.
// - Other commands hold between 117 and 200 ms.
// - Calibrate holds for the whole calibration run.
// - Programmed terminator follows each data string; default CR then LF.
// - Power-up or device clear restores the CR LF terminator.
// - Terminator command with one, two or zero characters before execute.
// - Two terminator characters are sent in programmed order.
`timescale 1ns/1ns
`include "geht_consts.svh"

module geht_top
   import geht_pkg::*;
#(
   parameter int          FUNC_HOLD_CYC  = `GEHT_FUNC_MS * `GEHT_CLK_KHZ,
   parameter int          AC_HOLD_CYC    = `GEHT_AC_FUNC_MS * `GEHT_CLK_KHZ,
   parameter int          OTHER_HOLD_CYC = `GEHT_OTHER_MS * `GEHT_CLK_KHZ,
   parameter logic [3:0]  AC_VOLT_CODE   = 4'h1,
   parameter logic [3:0]  AC_CURR_CODE   = 4'h2,
   parameter int          DW             = 8,
   parameter int          DEPTH          = 2
) (
   // Clock and reset
   input  wire logic          clk_sys_i,
   input  wire logic          nrst_i,
   // Device clear (DCL or SDC) pulse
   input  wire logic          dev_clear_i,
   // Received command bytes, handshake already complete
   input  wire logic          rx_valid_i,
   input  wire logic [7:0]    rx_data_i,
   output logic               rx_ready_o,
   // Instrument data string source
   input  wire logic          tx_valid_i,
   input  wire logic [DW-1:0] tx_data_i,
   input  wire logic          tx_last_i,
   output logic               tx_ready_o,
   // Talker output bytes
   output logic               out_valid_o,
   output logic [DW-1:0]      out_data_o,
   output logic               out_eoi_o,
   input  wire logic          out_ready_i,
   // Hold-off and execution
   output logic               nrfd_hold_o,
   output logic               exec_busy_o,
   output logic               cal_start_o,
   input  wire logic          cal_done_i,
   output logic               illegal_opt_o,
   output logic [1:0]         eoi_hold_opt_o
);

   localparam int CW = $clog2(AC_HOLD_CYC + 1);
   localparam int AW = $clog2(DEPTH);

   // Settings and parser state
   geht_pst_e   pst, next_pst;
   logic [1:0]  opt, next_opt, p_opt, next_p_opt;
   logic        p_opt_v, next_p_opt_v;
   logic [7:0]  term0, next_term0, term1, next_term1, p_t0, next_p_t0, p_t1, next_p_t1;
   logic [1:0]  tlen, next_tlen, p_tlen, next_p_tlen;
   logic        p_term_v, next_p_term_v;
   logic        p_func, next_p_func, p_ac, next_p_ac, p_cal, next_p_cal;
   logic        p_other, next_p_other, p_bad, next_p_bad;
   logic [CW-1:0] cnt, next_cnt;
   logic        cal_wait, next_cal_wait;
   logic        next_rx_ready, next_nrfd_hold, next_exec_busy, next_cal_start, next_illegal;
   logic        rx_take, is_exec, is_digit;
   logic [3:0]  fcode;

   // Characters a controller may not use as terminators
   function automatic logic forbidden(input logic [7:0] c);
      forbidden = (c >= `GEHT_CHR_UC_A && c <= `GEHT_CHR_UC_Z) ||
                  (c >= `GEHT_CHR_ZERO && c <= `GEHT_CHR_NINE) ||
                  c == `GEHT_CHR_BLANK || c == `GEHT_CHR_PLUS || c == `GEHT_CHR_SLASH ||
                  c == `GEHT_CHR_COMMA || c == `GEHT_CHR_DOT || c == `GEHT_CHR_LC_E;
   endfunction

   assign rx_take  = rx_valid_i && rx_ready_o;
   assign is_exec  = rx_data_i == `GEHT_CHR_EXEC;
   assign is_digit = rx_data_i >= `GEHT_CHR_ZERO && rx_data_i <= `GEHT_CHR_NINE;
   assign fcode    = rx_data_i[3:0];

   // Parser, settings and execution timing
   always_comb begin
      next_pst      = pst;
      next_opt      = opt;
      next_term0    = term0;
      next_term1    = term1;
      next_tlen     = tlen;
      next_p_opt    = p_opt;
      next_p_opt_v  = p_opt_v;
      next_p_t0     = p_t0;
      next_p_t1     = p_t1;
      next_p_tlen   = p_tlen;
      next_p_term_v = p_term_v;
      next_p_func   = p_func;
      next_p_ac     = p_ac;
      next_p_cal    = p_cal;
      next_p_other  = p_other;
      next_p_bad    = p_bad;
      next_cnt      = (cnt != '0) ? cnt - CW'(1) : cnt;
      next_cal_wait = cal_wait && !cal_done_i;
      next_cal_start = 1'b0;
      next_illegal  = 1'b0;
      if (dev_clear_i) begin
         // Defaults restored; pending string discarded
         next_opt      = `GEHT_OPT_DEFAULT;
         next_term0    = `GEHT_TERM0_DEFAULT;
         next_term1    = `GEHT_TERM1_DEFAULT;
         next_tlen     = `GEHT_TLEN_DEFAULT;
         next_pst      = GEHT_P_IDLE;
         next_p_opt_v  = 1'b0;
         next_p_term_v = 1'b0;
         next_p_func   = 1'b0;
         next_p_ac     = 1'b0;
         next_p_cal    = 1'b0;
         next_p_other  = 1'b0;
         next_p_bad    = 1'b0;
      end else if (rx_take && is_exec) begin
         // Execute: close the open command, then apply or reject the string
         next_p_bad = p_bad || pst == GEHT_P_OPT || pst == GEHT_P_FUNC;
         if (pst == GEHT_P_Y0 || pst == GEHT_P_Y1 || pst == GEHT_P_Y2) begin
            next_p_term_v = 1'b1;
            next_p_tlen   = (pst == GEHT_P_Y0) ? 2'h0 : (pst == GEHT_P_Y1) ? 2'h1 : 2'h2;
         end
         if (next_p_bad) begin
            next_illegal = 1'b1;
         end else begin
            if (p_opt_v) begin
               next_opt = p_opt;
            end
            if (next_p_term_v) begin
               next_term0 = p_t0;
               next_term1 = p_t1;
               next_tlen  = next_p_tlen;
            end
            // Calibrate wins, then function select, then any other command, in deciding the hold length
            if (p_cal) begin
               next_cal_wait  = 1'b1;
               next_cal_start = 1'b1;
            end else if (p_func) begin
               next_cnt = p_ac ? CW'(AC_HOLD_CYC) : CW'(FUNC_HOLD_CYC);
            end else if (p_other || p_opt_v || next_p_term_v) begin
               next_cnt = CW'(OTHER_HOLD_CYC);
            end
         end
         next_pst      = GEHT_P_IDLE;
         next_p_opt_v  = 1'b0;
         next_p_term_v = 1'b0;
         next_p_func   = 1'b0;
         next_p_ac     = 1'b0;
         next_p_cal    = 1'b0;
         next_p_other  = 1'b0;
         next_p_bad    = 1'b0;
      end else if (rx_take) begin
         unique case (pst)
            GEHT_P_IDLE: begin
               if (rx_data_i == `GEHT_CHR_OPT) begin
                  next_pst = GEHT_P_OPT;
               end else if (rx_data_i == `GEHT_CHR_TERM) begin
                  next_pst  = GEHT_P_Y0;
                  next_p_t0 = 8'h00;
                  next_p_t1 = 8'h00;
               end else if (rx_data_i == `GEHT_CHR_FUNC) begin
                  next_pst = GEHT_P_FUNC;
               end else if (rx_data_i == `GEHT_CHR_CAL) begin
                  next_p_cal = 1'b1;
               end else if (!is_digit) begin
                  next_p_other = 1'b1;
               end
            end
            GEHT_P_OPT: begin
               if (rx_data_i >= `GEHT_CHR_ZERO && rx_data_i <= `GEHT_CHR_THREE) begin
                  next_p_opt   = rx_data_i[1:0];
                  next_p_opt_v = 1'b1;
               end else begin
                  next_p_bad = 1'b1;
               end
               next_pst = GEHT_P_IDLE;
            end
            GEHT_P_FUNC: begin
               next_p_func = 1'b1;
               next_p_ac   = p_ac || (is_digit && (fcode == AC_VOLT_CODE || fcode == AC_CURR_CODE));
               next_p_bad  = p_bad || !is_digit;
               next_pst    = GEHT_P_IDLE;
            end
            GEHT_P_Y0: begin
               next_p_t0  = rx_data_i;
               next_p_bad = p_bad || forbidden(rx_data_i);
               next_pst   = GEHT_P_Y1;
            end
            GEHT_P_Y1: begin
               next_p_t1  = rx_data_i;
               next_p_bad = p_bad || forbidden(rx_data_i);
               next_pst   = GEHT_P_Y2;
            end
            GEHT_P_Y2: begin
               next_p_bad = 1'b1;                                    // Third character
            end
            default: begin
               next_pst = GEHT_P_IDLE;
            end
         endcase
      end
      // Hold NRFD while executing if the option asks for it
      // Hold starts only on an execute byte, so a clear during a free run cannot raise it
      next_exec_busy = next_cnt != '0 || next_cal_wait;
      next_nrfd_hold = next_exec_busy && !next_opt[`GEHT_OPT_NO_HOLD_BIT] &&
                       (nrfd_hold_o || (rx_take && is_exec && !dev_clear_i));
      next_rx_ready  = !next_nrfd_hold;
   end

   // Parser and settings registers
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pst           <= GEHT_P_IDLE;
         opt           <= `GEHT_OPT_DEFAULT;
         term0         <= `GEHT_TERM0_DEFAULT;
         term1         <= `GEHT_TERM1_DEFAULT;
         tlen          <= `GEHT_TLEN_DEFAULT;
         p_opt         <= 2'h0;
         p_opt_v       <= 1'b0;
         p_t0          <= 8'h00;
         p_t1          <= 8'h00;
         p_tlen        <= 2'h0;
         p_term_v      <= 1'b0;
         p_func        <= 1'b0;
         p_ac          <= 1'b0;
         p_cal         <= 1'b0;
         p_other       <= 1'b0;
         p_bad         <= 1'b0;
         cnt           <= '0;
         cal_wait      <= 1'b0;
         rx_ready_o    <= 1'b1;
         nrfd_hold_o   <= 1'b0;
         exec_busy_o   <= 1'b0;
         cal_start_o   <= 1'b0;
         illegal_opt_o <= 1'b0;
         eoi_hold_opt_o <= `GEHT_OPT_DEFAULT;
      end else begin
         pst           <= next_pst;
         opt           <= next_opt;
         term0         <= next_term0;
         term1         <= next_term1;
         tlen          <= next_tlen;
         p_opt         <= next_p_opt;
         p_opt_v       <= next_p_opt_v;
         p_t0          <= next_p_t0;
         p_t1          <= next_p_t1;
         p_tlen        <= next_p_tlen;
         p_term_v      <= next_p_term_v;
         p_func        <= next_p_func;
         p_ac          <= next_p_ac;
         p_cal         <= next_p_cal;
         p_other       <= next_p_other;
         p_bad         <= next_p_bad;
         cnt           <= next_cnt;
         cal_wait      <= next_cal_wait;
         rx_ready_o    <= next_rx_ready;
         nrfd_hold_o   <= next_nrfd_hold;
         exec_busy_o   <= next_exec_busy;
         cal_start_o   <= next_cal_start;
         illegal_opt_o <= next_illegal;
         eoi_hold_opt_o <= next_opt;
      end
   end

   // Two-entry buffer; a stalled talker back-pressures the data source
   logic [DW:0]   mem [DEPTH], next_mem [DEPTH];
   logic [AW-1:0] wp, next_wp, rp, next_rp;
   logic [AW:0]   fill, next_fill;
   geht_ost_e     ost, next_ost;
   logic          next_tx_ready, next_out_valid, next_out_eoi, buf_push, buf_pop, slot_free;
   logic [DW-1:0] next_out_data;

   assign buf_push  = tx_valid_i && tx_ready_o;
   assign slot_free = !out_valid_o || out_ready_i;

   // Output sequencer: data bytes, then terminator, EOI on the final byte
   always_comb begin
      next_ost       = ost;
      next_out_valid = out_valid_o && !out_ready_i;
      next_out_data  = out_data_o;
      next_out_eoi   = out_eoi_o;
      buf_pop        = 1'b0;
      if (slot_free) begin
         unique case (ost)
            GEHT_O_DATA: begin
               if (fill != '0) begin
                  buf_pop        = 1'b1;
                  next_out_valid = 1'b1;
                  next_out_data  = mem[rp][DW-1:0];
                  next_out_eoi   = mem[rp][DW] && tlen == 2'h0 && !opt[`GEHT_OPT_NO_EOI_BIT];
                  if (mem[rp][DW] && tlen != 2'h0) begin
                     next_ost = GEHT_O_TERM0;
                  end
               end
            end
            GEHT_O_TERM0: begin
               next_out_valid = 1'b1;
               next_out_data  = DW'(term0);
               next_out_eoi   = tlen == 2'h1 && !opt[`GEHT_OPT_NO_EOI_BIT];
               next_ost       = (tlen == 2'h2) ? GEHT_O_TERM1 : GEHT_O_DATA;
            end
            GEHT_O_TERM1: begin
               next_out_valid = 1'b1;
               next_out_data  = DW'(term1);
               next_out_eoi   = !opt[`GEHT_OPT_NO_EOI_BIT];
               next_ost       = GEHT_O_DATA;
            end
            default: begin
               next_ost = GEHT_O_DATA;
            end
         endcase
      end
      next_mem = mem;
      if (buf_push) begin
         next_mem[wp] = {tx_last_i, tx_data_i};
      end
      next_wp       = buf_push ? AW'(wp + 1'b1) : wp;
      next_rp       = buf_pop ? AW'(rp + 1'b1) : rp;
      next_fill     = fill + (AW+1)'(buf_push) - (AW+1)'(buf_pop);
      next_tx_ready = next_fill != (AW+1)'(DEPTH);
   end

   // Buffer and output registers
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mem         <= '{default: '0};
         wp          <= '0;
         rp          <= '0;
         fill        <= '0;
         ost         <= GEHT_O_DATA;
         tx_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
         out_eoi_o   <= 1'b0;
      end else begin
         mem         <= next_mem;
         wp          <= next_wp;
         rp          <= next_rp;
         fill        <= next_fill;
         ost         <= next_ost;
         tx_ready_o  <= next_tx_ready;
         out_valid_o <= next_out_valid;
         out_data_o  <= next_out_data;
         out_eoi_o   <= next_out_eoi;
      end
   end

endmodule

/* File: verification/geht_chk.sv */
`timescale 1ns/1ns
`include "geht_consts.svh"

module geht_chk (
   // Watched ports
   input wire logic       clk_sys_i,
   input wire logic       nrst_i,
   input wire logic       dev_clear_i,
   input wire logic       rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic       rx_ready_o,
   input wire logic       out_valid_o,
   input wire logic [7:0] out_data_o,
   input wire logic       out_eoi_o,
   input wire logic       out_ready_i,
   input wire logic       nrfd_hold_o,
   input wire logic       exec_busy_o,
   input wire logic       cal_start_o,
   input wire logic       illegal_opt_o,
   input wire logic [1:0] eoi_hold_opt_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   // Hold-off and byte acceptance are two faces of one wire
   a_ready_hold: assert property (rx_ready_o == !nrfd_hold_o)
      else $error("command ready not inverse of hold");
   a_hold_after_exec: assert property ($rose(nrfd_hold_o) |->
      $past(rx_valid_i && rx_ready_o && rx_data_i == `GEHT_CHR_EXEC))
      else $error("hold began without an execute byte");
   a_hold_opt: assert property (nrfd_hold_o |-> !eoi_hold_opt_o[`GEHT_OPT_NO_HOLD_BIT])
      else $error("hold with hold-off disabled");
   a_hold_busy: assert property (nrfd_hold_o |-> exec_busy_o)
      else $error("bus held while idle");
   a_eoi_opt: assert property (out_valid_o && eoi_hold_opt_o[`GEHT_OPT_NO_EOI_BIT] |-> !out_eoi_o)
      else $error("end flag sent with it disabled");
   a_out_stable: assert property (out_valid_o && !out_ready_i && !dev_clear_i |=>
      out_valid_o && $stable(out_data_o) && $stable(out_eoi_o))
      else $error("talker byte changed while stalled");
   a_clear_default: assert property (dev_clear_i |=> eoi_hold_opt_o == `GEHT_OPT_DEFAULT)
      else $error("clear did not restore option");
   a_illegal_keep: assert property (illegal_opt_o |-> $stable(eoi_hold_opt_o))
      else $error("rejected string changed option");
   a_cal_busy: assert property (cal_start_o |-> exec_busy_o ##1 !cal_start_o)
      else $error("calibration start not a busy pulse");
endmodule

bind geht_top geht_chk chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .dev_clear_i(dev_clear_i),
   .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .out_valid_o(out_valid_o),
   .out_data_o(out_data_o), .out_eoi_o(out_eoi_o), .out_ready_i(out_ready_i), .nrfd_hold_o(nrfd_hold_o),
   .exec_busy_o(exec_busy_o), .cal_start_o(cal_start_o), .illegal_opt_o(illegal_opt_o),
   .eoi_hold_opt_o(eoi_hold_opt_o));

/* File: verification/geht_listener.sv */
`timescale 1ns/1ns

module geht_listener (
   // Clock, reset, pacing
   input  wire logic       clk_sys_i,
   input  wire logic       nrst_i,
   input  wire logic       slow_i,
   // Talker side of the block
   input  wire logic       out_valid_i,
   input  wire logic [7:0] out_data_i,
   input  wire logic       out_eoi_i,
   output logic            ready_o
);
   logic [7:0] got_data[$];
   logic       got_eoi[$];
   logic [1:0] phase;

   initial begin
      ready_o = 1'b0;
      phase = 2'h0;
   end

   // Log at the edge, retime ready just after; slow mode takes one byte in four
   always @(posedge clk_sys_i) begin
      if (nrst_i && out_valid_i && ready_o) begin
         got_data.push_back(out_data_i);
         got_eoi.push_back(out_eoi_i);
      end
      phase = phase + 2'h1;
      #10 ready_o = !slow_i || phase == 2'h0;
   end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ns

module testbench;
   logic       clk_sys_i, nrst_i, dev_clear_i, rx_valid_i, tx_valid_i, tx_last_i, cal_done_i, slow, full_seen;
   logic [7:0] rx_data_i, tx_data_i;
   wire logic  rx_ready_o, tx_ready_o, out_valid_o, out_eoi_o, out_ready_i, nrfd_hold_o, exec_busy_o;
   wire logic  cal_start_o, illegal_opt_o;
   wire logic [7:0] out_data_o;
   wire logic [1:0] eoi_hold_opt_o;
   int         fail_count, n_compared;

   // Short hold counts keep the run brief
   geht_top #(.FUNC_HOLD_CYC(20), .AC_HOLD_CYC(40), .OTHER_HOLD_CYC(10)) dut (.clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i), .dev_clear_i(dev_clear_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
      .rx_ready_o(rx_ready_o), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_last_i(tx_last_i),
      .tx_ready_o(tx_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_eoi_o(out_eoi_o),
      .out_ready_i(out_ready_i), .nrfd_hold_o(nrfd_hold_o), .exec_busy_o(exec_busy_o),
      .cal_start_o(cal_start_o), .cal_done_i(cal_done_i), .illegal_opt_o(illegal_opt_o),
      .eoi_hold_opt_o(eoi_hold_opt_o));
   geht_listener listener (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .slow_i(slow), .out_valid_i(out_valid_o),
      .out_data_i(out_data_o), .out_eoi_i(out_eoi_o), .ready_o(out_ready_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   // Notes when the two-entry buffer refuses a byte
   always @(posedge clk_sys_i) if (tx_ready_o === 1'b0) full_seen = 1'b1;

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Each byte held until taken at an edge with ready high
   task automatic send_cmd(input string s);
      @(posedge clk_sys_i);
      #10;
      for (int i = 0; i < s.len(); i++) begin
         rx_valid_i = 1'b1;
         rx_data_i = s[i];
         do @(posedge clk_sys_i); while (rx_ready_o !== 1'b1);
         #10;
      end
      rx_valid_i = 1'b0;
   endtask

   // Sends a data string and compares what the listener logged
   task automatic run_data(input string what, input string d, input string exp, input logic eoi_on);
      @(posedge clk_sys_i);
      #10;
      listener.got_data.delete();
      listener.got_eoi.delete();
      for (int i = 0; i < d.len(); i++) begin
         tx_valid_i = 1'b1;
         tx_data_i = d[i];
         tx_last_i = (i == d.len() - 1);
         do @(posedge clk_sys_i); while (tx_ready_o !== 1'b1);
         #10;
      end
      tx_valid_i = 1'b0;
      tx_last_i = 1'b0;
      for (int w = 0; w < 300 && listener.got_data.size() < exp.len(); w++) @(posedge clk_sys_i);
      repeat (8) @(posedge clk_sys_i);
      chk({what, " count"}, 8'(exp.len()), 8'(listener.got_data.size()));
      for (int i = 0; i < exp.len() && i < listener.got_data.size(); i++) begin
         chk({what, " byte"}, exp[i], listener.got_data[i]);
         chk({what, " eoi"}, {7'h0, eoi_on && i == exp.len() - 1}, {7'h0, listener.got_eoi[i]});
      end
   endtask

   // Counts busy and hold cycles following a command string
   task automatic hold_len(input string cmd, input int busy_exp, input int hold_exp);
      int bcnt;
      int hcnt;
      bcnt = 0;
      hcnt = 0;
      send_cmd(cmd);
      repeat (400) begin
         @(posedge clk_sys_i);
         if (exec_busy_o === 1'b1) bcnt++;
         if (nrfd_hold_o === 1'b1) hcnt++;
      end
      chk({cmd, " busy"}, 8'(busy_exp), 8'(bcnt));
      chk({cmd, " hold"}, 8'(hold_exp), 8'(hcnt));
   endtask

   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic t_reset();
      chk("option", 8'h00, {6'h0, eoi_hold_opt_o});
      run_data("default", "A", "A\015\012", 1'b1);
      $display("Test reset defaults done");
   endtask

   task automatic t_options();
      string s;
      for (int k = 0; k < 4; k++) begin
         s = "K0X";
         s[1] = 8'h30 + k;
         send_cmd(s);
         repeat (15) @(posedge clk_sys_i);
         chk("option", 8'(k), {6'h0, eoi_hold_opt_o});
         hold_len("F0X", 20, k < 2 ? 20 : 0);
         run_data("option", "Z", "Z\015\012", k[0] == 1'b0);
      end
      send_cmd("K0X");
      repeat (15) @(posedge clk_sys_i);
      hold_len("F1X", 40, 40);
      hold_len("F2X", 40, 40);
      hold_len("RX", 10, 10);
      hold_len("X", 0, 0);
      send_cmd("K9X");
      chk("bad option", 8'h01, {7'h0, illegal_opt_o});
      chk("kept option", 8'h00, {6'h0, eoi_hold_opt_o});
      $display("Test options and holds done");
   endtask

   task automatic t_cal();
      send_cmd("CX");
      chk("cal start", 8'h01, {7'h0, cal_start_o});
      repeat (60) @(posedge clk_sys_i);
      #10;
      chk("cal hold", 8'h01, {7'h0, nrfd_hold_o});
      cal_done_i = 1'b1;
      @(posedge clk_sys_i);
      #10;
      cal_done_i = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #10;
      chk("cal release", 8'h00, {7'h0, nrfd_hold_o});
      $display("Test calibration done");
   endtask

   task automatic t_term();
      send_cmd("Y\012\015X");
      run_data("swap", "B", "B\012\015", 1'b1);
      send_cmd("Y*X");
      run_data("single", "B", "B*", 1'b1);
      send_cmd("YX");
      run_data("none", "B", "B", 1'b1);
      send_cmd("YeX");
      chk("illegal", 8'h01, {7'h0, illegal_opt_o});
      run_data("kept", "B", "B", 1'b1);
      $display("Test terminators done");
   endtask

   task automatic t_clear();
      send_cmd("K3X");
      repeat (15) @(posedge clk_sys_i);
      #10;
      dev_clear_i = 1'b1;
      @(posedge clk_sys_i);
      #10;
      dev_clear_i = 1'b0;
      @(posedge clk_sys_i);
      #10;
      chk("cleared option", 8'h00, {6'h0, eoi_hold_opt_o});
      slow = 1'b1;
      full_seen = 1'b0;
      run_data("cleared", "ABCD", "ABCD\015\012", 1'b1);
      chk("buffer full", 8'h01, {7'h0, full_seen});
      slow = 1'b0;
      $display("Test clear and stall done");
   endtask

   initial begin
      {nrst_i, dev_clear_i, rx_valid_i, tx_valid_i, tx_last_i, cal_done_i, slow, full_seen} = '0;
      rx_data_i = 8'h00;
      tx_data_i = 8'h00;
      repeat (4) @(posedge clk_sys_i);
      #10 nrst_i = 1'b1;
      t_reset();
      t_options();
      t_cal();
      t_term();
      t_clear();
      conclude();
   end

   // Whole run needs well under this span
   initial begin
      #(100 * 60000);
      fail_count++;
      conclude();
   end
endmodule
